/* File: core/cosc_pkg.sv */
package cosc_pkg;
   // Register word offsets (byte addresses)
   localparam logic [3:0] CTRL0_OFS = 4'h0;
   localparam logic [3:0] SHUT_OFS = 4'h4;
   localparam logic [3:0] SRCSEL_OFS = 4'h8;
   localparam logic [3:0] POL_OFS = 4'hc;
   localparam logic [3:0] CNT_OFS = 4'h0;
   localparam int CNT_NUM = 6;
   localparam logic [5:0] CNT_BASE = 6'h10;
   // Control register 0 fields
   localparam int EN_BIT = 7;
   localparam int LD_BIT = 6;
   localparam int CS_LSB = 3;
   localparam int MD_LSB = 0;
   localparam logic [7:0] CTRL0_RST = 8'h00;
   localparam logic [7:0] CTRL0_MASK = 8'hdf;
   // Shutdown control fields
   localparam int ASE_BIT = 7;
   localparam int ARS_BIT = 6;
   localparam int OVBD_LSB = 2;
   localparam int OVAC_LSB = 0;
   localparam logic [7:0] SHUT_RST = 8'h80;
   localparam logic [7:0] SHUT_MASK = 8'hcf;
   // Override encodings
   localparam logic [1:0] OV_INACT = 2'h0;
   localparam logic [1:0] OV_HIZ = 2'h1;
   localparam logic [1:0] OV_LOW = 2'h2;
   localparam logic [1:0] OV_HIGH = 2'h3;
   // Clock select encodings
   localparam logic [1:0] CS_DIV4 = 2'h0;
   localparam logic [1:0] CS_SYS = 2'h1;
   localparam logic [1:0] CS_FAST = 2'h2;
   localparam logic [1:0] DIV4_LAST = 2'h3;

   typedef enum logic [2:0] {
      MD_STEER = 3'h0, MD_SYNCSTEER = 3'h1, MD_FWDBRIDGE = 3'h2,
      MD_REVBRIDGE = 3'h3, MD_HALFBRIDGE = 3'h4, MD_PUSHPULL = 3'h5
   } cosc_mode_e;

   typedef enum {ST_SHUT, ST_WAITRISE, ST_RUN} cosc_state_e;

   typedef struct packed {
      logic [3:0] lvl;
      logic [3:0] oe;
   } cosc_pins_s;
endpackage : cosc_pkg

/* File: core/cosc_shutdown_ctrl.sv */
`timescale 1ns/1ns
module cosc_shutdown_ctrl
#(
   parameter int NSRC = 8
)
(
   // System
   input wire logic clk,
   input wire logic rstn,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Events and faults
   input wire logic pinIn,
   input wire logic [NSRC-1:0] shutdownSrc,
   input wire logic riseEvent,
   input wire logic fallEvent,
   input wire logic [3:0] pwmDrive,
   input wire logic sleepMode,
   // Generator side
   output cosc_pkg::cosc_pins_s pins,
   output logic genRun,
   output logic genClkEn,
   output logic fastOscKeep,
   output cosc_pkg::cosc_mode_e genMode,
   output logic [47:0] workCounts
);
   import cosc_pkg::*;

   logic [7:0] ctrl0_ff;
   logic [7:0] shut_ff;
   logic [7:0] srcSel_ff;
   logic [3:0] pol_ff;
   logic [7:0] cntReg_ff [CNT_NUM];
   logic [7:0] cntBuf_ff [CNT_NUM];
   logic [1:0] pinSync_ff;
   logic [NSRC-1:0] srcSync1_ff;
   logic [NSRC-1:0] srcSync2_ff;
   logic [1:0] div_ff;
   logic ack_ff;
   cosc_state_e state_ff;
   cosc_state_e nxt_state;
   logic faultNow;
   logic wrStb;
   logic rdTake;
   logic [31:0] rdData;
   logic [3:0] inact;
   logic [7:0] wrByte;
   logic enabled;
   logic loadEvent;

   assign enabled = ctrl0_ff[EN_BIT];
   assign wrStb = wb_cyc_i && wb_stb_i && wb_we_i && !ack_ff && wb_sel_i[0];
   assign rdTake = wb_cyc_i && wb_stb_i && !ack_ff;
   assign wrByte = wb_dat_i[7:0];

   // Faults come from pins and other domains
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         pinSync_ff <= 2'h3;
         srcSync1_ff <= '1;
         srcSync2_ff <= '1;
      end
      else
      begin
         pinSync_ff <= {pinSync_ff[0], pinIn};
         srcSync1_ff <= shutdownSrc;
         srcSync2_ff <= srcSync1_ff;
      end
   end

   // Source 0 is the selectable pin; low level means fault
   always_comb
   begin
      faultNow = !pinSync_ff[1] && srcSel_ff[0];
      for (int i = 1; i < NSRC && i < 8; i++)
      begin
         if (srcSel_ff[i] && !srcSync2_ff[i])
         begin
            faultNow = 1'b1;
         end
      end
   end

   // Single-cycle answer; idle while reset is held
   always_ff @(posedge clk)
   begin
      ack_ff <= rstn && rdTake;
   end
   assign wb_ack_o = ack_ff;

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         ctrl0_ff <= CTRL0_RST;
      end
      else if (wrStb && wb_adr_i == {4'h0, CTRL0_OFS})
      begin
         ctrl0_ff <= wrByte & CTRL0_MASK;
      end
      else if (loadEvent)
      begin
         ctrl0_ff[LD_BIT] <= 1'b0;
      end
   end

   // Shutdown flag: fault set wins over any software clear
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         shut_ff <= SHUT_RST;
      end
      else
      begin
         if (wrStb && wb_adr_i == {4'h0, SHUT_OFS})
         begin
            shut_ff <= wrByte & SHUT_MASK;
         end
         if (faultNow)
         begin
            shut_ff[ASE_BIT] <= 1'b1;
         end
         else if (shut_ff[ARS_BIT] && shut_ff[ASE_BIT])
         begin
            shut_ff[ASE_BIT] <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         srcSel_ff <= 8'h00;
         pol_ff <= 4'h0;
      end
      else if (wrStb && wb_adr_i == {4'h0, SRCSEL_OFS})
      begin
         srcSel_ff <= wrByte;
      end
      else if (wrStb && wb_adr_i == {4'h0, POL_OFS})
      begin
         pol_ff <= wrByte[3:0];
      end
   end

   // While enabled, transfer only on an input event so counts stay coherent
   assign loadEvent = enabled && ctrl0_ff[LD_BIT] && (riseEvent || fallEvent);

   generate
      for (genvar g = 0; g < CNT_NUM; g++)
      begin : gCnt
         always_ff @(posedge clk)
         begin
            if (!rstn)
            begin
               cntReg_ff[g] <= 8'h00;
               cntBuf_ff[g] <= 8'h00;
            end
            else
            begin
               if (wrStb && wb_adr_i == {2'h0, CNT_BASE} + 8'(4 * g))
               begin
                  cntReg_ff[g] <= wrByte;
                  if (!enabled)
                  begin
                     cntBuf_ff[g] <= wrByte;
                  end
               end
               if (loadEvent)
               begin
                  cntBuf_ff[g] <= cntReg_ff[g];
               end
            end
         end
         assign workCounts[8*g +: 8] = cntBuf_ff[g];
      end
   endgenerate

   always_comb
   begin
      rdData = 32'h0;
      case (wb_adr_i)
         {4'h0, CTRL0_OFS}: rdData[7:0] = ctrl0_ff;
         {4'h0, SHUT_OFS}: rdData[7:0] = shut_ff;
         {4'h0, SRCSEL_OFS}: rdData[7:0] = srcSel_ff;
         {4'h0, POL_OFS}: rdData[3:0] = pol_ff;
         default:
         begin
            for (int i = 0; i < CNT_NUM; i++)
            begin
               if (wb_adr_i == {2'h0, CNT_BASE} + 8'(4 * i))
               begin
                  rdData[7:0] = cntReg_ff[i];
               end
            end
         end
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         wb_dat_o <= 32'h0;
      end
      else if (rdTake)
      begin
         wb_dat_o <= rdData;
      end
   end

   // Resume only on a rising event after the flag drops
   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         ST_SHUT, ST_WAITRISE:
         begin
            if (shut_ff[ASE_BIT]) nxt_state = ST_SHUT;
            else if (riseEvent && enabled) nxt_state = ST_RUN;
            else nxt_state = ST_WAITRISE;
         end
         ST_RUN: if (shut_ff[ASE_BIT] || !enabled) nxt_state = ST_SHUT;
         default: nxt_state = ST_SHUT;
      endcase
      if (faultNow)
      begin
         nxt_state = ST_SHUT;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         state_ff <= ST_SHUT;
      end
      else
      begin
         state_ff <= nxt_state;
      end
   end

   // Inactive drive is low on all four pins, polarity applied
   assign inact = 4'h0 ^ pol_ff;

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         pins <= '0;
      end
      else
      begin
         for (int i = 0; i < 4; i++)
         begin
            pins.oe[i] <= 1'b1;
            if (state_ff != ST_RUN || nxt_state == ST_SHUT)
            begin
               case (shut_ff[(i[0] ? OVBD_LSB : OVAC_LSB) +: 2])
                  OV_INACT: pins.lvl[i] <= inact[i];
                  OV_HIZ:
                  begin
                     pins.lvl[i] <= 1'b0;
                     pins.oe[i] <= 1'b0;
                  end
                  OV_LOW: pins.lvl[i] <= 1'b0;
                  default: pins.lvl[i] <= 1'b1;
               endcase
            end
            else
            begin
               pins.lvl[i] <= pwmDrive[i] ^ pol_ff[i];
            end
         end
      end
   end

   // Generator clock enable; sleep does not stop the block
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         div_ff <= 2'h0;
      end
      else
      begin
         div_ff <= div_ff + 2'h1;
      end
   end

   always_comb
   begin
      case (ctrl0_ff[CS_LSB +: 2])
         CS_DIV4: genClkEn = (div_ff == DIV4_LAST);
         CS_SYS: genClkEn = 1'b1;
         CS_FAST: genClkEn = 1'b1;
         default: genClkEn = 1'b0;
      endcase
   end

   assign fastOscKeep = enabled && ctrl0_ff[CS_LSB +: 2] == CS_FAST && sleepMode;
   assign genRun = state_ff == ST_RUN;
   assign genMode = cosc_mode_e'(ctrl0_ff[MD_LSB +: 3]);

   sequence faultSeen;
      faultNow;
   endsequence

   forceShut_a: assert property (@(posedge clk) disable iff (!rstn)
      faultSeen |=> shut_ff[ASE_BIT])
      else $error("shutdown flag not held by fault");
   noRunFault_a: assert property (@(posedge clk) disable iff (!rstn)
      faultSeen |=> state_ff == ST_SHUT)
      else $error("generator ran during fault");
   autoClear_a: assert property (@(posedge clk) disable iff (!rstn)
      !faultNow && shut_ff[ARS_BIT] && shut_ff[ASE_BIT] && !wrStb |=> !shut_ff[ASE_BIT])
      else $error("auto restart did not clear flag");
   resumeRise_a: assert property (@(posedge clk) disable iff (!rstn)
      state_ff != ST_RUN ##1 state_ff == ST_RUN |-> $past(riseEvent))
      else $error("resume without rising event");
   ldClear_a: assert property (@(posedge clk) disable iff (!rstn)
      loadEvent && !wrStb |=> !ctrl0_ff[LD_BIT])
      else $error("load bit not cleared");
   bufHold_a: assert property (@(posedge clk) disable iff (!rstn)
      enabled && !loadEvent |=> cntBuf_ff[0] == $past(cntBuf_ff[0]))
      else $error("buffer changed without load");
   bit5Zero_a: assert property (@(posedge clk) disable iff (!rstn)
      !ctrl0_ff[5])
      else $error("unimplemented bit set");
   ovLow_a: assert property (@(posedge clk) disable iff (!rstn)
      state_ff == ST_SHUT && shut_ff[OVAC_LSB +: 2] == OV_LOW ##1
      $stable(shut_ff) |-> !pins.lvl[0] && pins.oe[0])
      else $error("forced low override wrong");
endmodule : cosc_shutdown_ctrl

/* File: test/cosc_event_src.sv */
`timescale 1ns/1ns
module cosc_event_src
#(
   parameter int PERIOD = 16
)
(
   // System
   input wire logic clk,
   input wire logic rstn,
   // Control
   input wire logic run,
   // Events
   output logic riseEvent,
   output logic fallEvent,
   output logic [3:0] pwmDrive
);
   logic [7:0] phase_ff;

   always_ff @(posedge clk)
   begin
      if (!rstn || !run)
         phase_ff <= 8'h00;
      else
         phase_ff <= (phase_ff == 8'(PERIOD - 1)) ? 8'h00 : phase_ff + 8'h01;
   end

   // Stopped source sends no events at all
   assign riseEvent = run && phase_ff == 8'h01;
   assign fallEvent = run && phase_ff == 8'(PERIOD / 2 + 1);
   assign pwmDrive = (phase_ff >= 8'h01 && phase_ff <= 8'(PERIOD / 2)) ? 4'h5 : 4'ha;
endmodule : cosc_event_src

/* File: test/testbench.sv */
`timescale 1ns/1ns
module testbench;
   import cosc_pkg::*;
   localparam logic [7:0] A_C0 = {4'h0, CTRL0_OFS};
   localparam logic [7:0] A_SH = {4'h0, SHUT_OFS};
   localparam logic [7:0] A_SS = {4'h0, SRCSEL_OFS};
   localparam logic [7:0] A_PO = {4'h0, POL_OFS};
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, pinIn = 1'b1, sleepMode = 1'b0;
   logic evRun = 1'b0;
   logic [7:0] wbAdr = 8'h00, shutdownSrc = 8'hff, rdv;
   logic [3:0] wbSel = 4'h0;
   logic [31:0] wbDatI = 32'h0, wbDatO;
   logic wbAck, riseEvent, fallEvent, genRun, genClkEn, fastOscKeep;
   logic [3:0] pwmDrive;
   cosc_pins_s pins;
   cosc_mode_e genMode;
   logic [47:0] workCounts;
   int errors = 0;
   int checks = 0;
   int cycles = 0;

   always #10 clk = ~clk;

   cosc_shutdown_ctrl i_cosc_shutdown_ctrl (.clk(clk), .rstn(rstn), .wb_cyc_i(wbCyc),
      .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI),
      .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .pinIn(pinIn), .shutdownSrc(shutdownSrc),
      .riseEvent(riseEvent), .fallEvent(fallEvent), .pwmDrive(pwmDrive),
      .sleepMode(sleepMode), .pins(pins), .genRun(genRun), .genClkEn(genClkEn),
      .fastOscKeep(fastOscKeep), .genMode(genMode), .workCounts(workCounts));
   cosc_event_src i_cosc_event_src (.clk(clk), .rstn(rstn), .run(evRun),
      .riseEvent(riseEvent), .fallEvent(fallEvent), .pwmDrive(pwmDrive));

   task end_sim;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : end_sim

   task chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
      checks++;
      if (got !== exp)
      begin
         errors++;
         $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : chk

   task tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick

   task bus(input logic we, input logic [7:0] adr, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbAdr <= adr;
      wbSel <= 4'h1;
      wbDatI <= {24'h0, d};
      @(posedge clk);
      while (wbAck !== 1'b1 && n < 50)
      begin
         @(posedge clk);
         n++;
      end
      chk(16'(wbAck), 16'h1, "ack");
      rdv = wbDatO[7:0];
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      wbWe <= 1'b0;
   endtask : bus

   task rdchk(input logic [7:0] adr, input logic [7:0] exp, input string msg);
      bus(1'b0, adr, 8'h00);
      chk({8'h0, rdv}, {8'h0, exp}, msg);
   endtask : rdchk

   task wait_run;
      int n;
      n = 0;
      while (genRun !== 1'b1 && n < 100)
      begin
         @(posedge clk);
         n++;
      end
   endtask : wait_run

   task t_reset;
      rdchk(A_C0, CTRL0_RST, "ctrl0 reset");
      rdchk(A_SH, SHUT_RST, "shutdown reset");
      rdchk(8'h30, 8'h00, "unmapped");
      bus(1'b1, A_C0, 8'hff);
      rdchk(A_C0, 8'hdf, "bit 5");
      bus(1'b1, A_C0, 8'h00);
      $display("t_reset done");
   endtask : t_reset

   task t_ctrl;
      int n;
      logic [1:0] cs;
      for (int m = 0; m < 6; m++)
      begin
         cs = 2'(m % 4);
         n = 0;
         bus(1'b1, A_C0, {3'b100, cs, 3'(m)});
         repeat (8)
         begin
            @(posedge clk);
            n += int'(genClkEn);
         end
         chk(16'(genMode), 16'(m), "mode");
         if (cs != CS_FAST)
            chk(16'(n), (cs == CS_DIV4) ? 16'h2 : (cs == CS_SYS) ? 16'h8 : 16'h0, "ticks");
      end
      bus(1'b1, A_C0, 8'h90);
      sleepMode <= 1'b1;
      tick(2);
      chk(16'(fastOscKeep), 16'h1, "osc kept");
      sleepMode <= 1'b0;
      tick(2);
      chk(16'(fastOscKeep), 16'h0, "osc free");
      bus(1'b1, A_C0, 8'h00);
      $display("t_ctrl done");
   endtask : t_ctrl

   task t_override;
      logic [1:0] f;
      logic [3:0] p;
      for (int k = 0; k < 2; k++)
      begin
         p = k ? 4'ha : 4'h0;
         bus(1'b1, A_PO, {4'h0, p});
         for (int ac = 0; ac < 4; ac++)
         begin
            bus(1'b1, A_SH, 8'(8'h80 | ((3 - ac) << 2) | ac));
            tick(2);
            for (int i = 0; i < 4; i++)
            begin
               f = i[0] ? 2'(3 - ac) : 2'(ac);
               chk(16'(pins.oe[i]), 16'(f != OV_HIZ), "oe");
               if (f != OV_HIZ)
                  chk(16'(pins.lvl[i]), 16'((f == OV_INACT) ? p[i] : f[0]), "lvl");
            end
         end
      end
      $display("t_override done");
   endtask : t_override

   task t_load;
      int n;
      n = 0;
      bus(1'b1, 8'h10, 8'h11);
      bus(1'b1, 8'h14, 8'h33);
      bus(1'b1, 8'h24, 8'h55);
      tick(2);
      chk(workCounts[15:0], 16'h3311, "direct copy");
      chk(16'(workCounts[47:40]), 16'h55, "direct copy 5");
      bus(1'b1, A_C0, 8'h88);
      bus(1'b1, 8'h14, 8'h22);
      bus(1'b1, 8'h24, 8'h66);
      bus(1'b1, A_C0, 8'hc8);
      tick(2);
      chk(16'(workCounts[15:8]), 16'h33, "held");
      chk(16'(workCounts[47:40]), 16'h55, "held 5");
      rdchk(A_C0, 8'hc8, "load pending");
      evRun <= 1'b1;
      while (rdv[6] !== 1'b0 && n < 20)
      begin
         bus(1'b0, A_C0, 8'h00);
         n++;
      end
      chk(16'(rdv), 16'h88, "load done");
      chk(16'(workCounts[15:8]), 16'h22, "loaded");
      chk(16'(workCounts[47:40]), 16'h66, "loaded 5");
      rdchk(8'h24, 8'h66, "count read");
      $display("t_load done");
   endtask : t_load

   task t_restart;
      bus(1'b1, A_C0, 8'h00);
      bus(1'b1, A_PO, 8'h00);
      bus(1'b1, A_SH, 8'h8f);
      bus(1'b1, A_SS, 8'h03);
      bus(1'b1, A_C0, 8'h88);
      shutdownSrc[1] <= 1'b0;
      tick(6);
      bus(1'b1, A_SH, 8'h0f);
      rdchk(A_SH, 8'h8f, "clear refused");
      shutdownSrc[1] <= 1'b1;
      tick(6);
      bus(1'b1, A_SH, 8'h0f);
      chk(16'(genRun), 16'h0, "early run");
      wait_run;
      chk(16'(genRun), 16'h1, "restart");
      tick(2);
      chk(16'(pins.lvl), 16'(pwmDrive), "drive");
      bus(1'b1, A_SH, 8'h8f);
      tick(2);
      chk(16'(genRun), 16'h0, "soft shut");
      chk(16'(pins.lvl), 16'hf, "soft shut lvl");
      $display("t_restart done");
   endtask : t_restart

   task t_auto;
      bus(1'b1, A_SH, 8'h4f);
      wait_run;
      pinIn <= 1'b0;
      tick(6);
      rdchk(A_SH, 8'hcf, "pin fault");
      chk(16'(genRun), 16'h0, "pin stop");
      pinIn <= 1'b1;
      wait_run;
      chk(16'(genRun), 16'h1, "auto run");
      rdchk(A_SH, 8'h4f, "auto clear");
      bus(1'b1, A_C0, 8'h08);
      tick(2);
      chk(16'(genRun), 16'h0, "disabled stop");
      $display("t_auto done");
   endtask : t_auto

   // Hang guard, well above the few hundred cycles the tests need
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         errors++;
         end_sim;
      end
   end

   initial
   begin
      tick(20);
      rstn <= 1'b1;
      t_reset;
      t_ctrl;
      t_override;
      t_load;
      t_restart;
      t_auto;
      end_sim;
   end
endmodule : testbench
